// file: common/vxcfg_defines.vh
// vxcfg_defines.vh - offsets, field positions and fixed codes
// of the extender configuration register bank.
// assumes: included by bare name; definitions only.
`ifndef VXCFG_DEFINES_VH
`define VXCFG_DEFINES_VH

////////////////////////////////////////////////////////////////
// register byte offsets in the configuration space
`define VXCFG_OFS_IDENT      6'h00
`define VXCFG_OFS_DEVTYPE    6'h02
`define VXCFG_OFS_STATCTL    6'h04
`define VXCFG_OFS_MODSEL     6'h08
`define VXCFG_OFS_LAWIN      6'h0a

////////////////////////////////////////////////////////////////
// identification register fields
`define VXCFG_DEVICE_CLASS_FIELD_EXT   2'h1
`define VXCFG_ADDRSP_A16     2'h3
// arbitrary neutral maker code
`define VXCFG_MAKER_CODE     12'h5a5

////////////////////////////////////////////////////////////////
// device type register fields
`define VXCFG_REQMEM_NONE    4'hf
// arbitrary neutral model code, bit 11 added from slot strap
`define VXCFG_MODEL_LOW      11'h0a5

////////////////////////////////////////////////////////////////
// status/control register fields
`define VXCFG_SC_MODSEL_BIT  14
`define VXCFG_SC_ORIGIN_BIT  8
`define VXCFG_SC_READY_BIT   3
`define VXCFG_SC_PASS_BIT    2
`define VXCFG_SC_SRST_BIT    0
// arbitrary neutral extended type codes
`define VXCFG_EXTTYPE_CARD   4'h9
`define VXCFG_EXTTYPE_NONE   4'h8
// arbitrary neutral hardware revision code
`define VXCFG_REVISION       4'h7

////////////////////////////////////////////////////////////////
// module-select register fields
`define VXCFG_MS_DRVEN_BIT   13
`define VXCFG_MS_LINES       13

////////////////////////////////////////////////////////////////
// logical address window register fields
`define VXCFG_LA_EN_BIT      14
`define VXCFG_LA_DIR_BIT     13
`define VXCFG_LA_WMASK       16'h67ff
`define VXCFG_LA_MSB_RANGE   8'h7f

`endif

// file: verilog/vxcfg_la_window.v
// vxcfg_la_window.v - logical address window comparator.
// assumes: register value and query are stable in the same
// cycle; the caller registers the result.
`include "vxcfg_defines.vh"

module vxcfg_la_window (
   input  wire [15:0] win_i,
   input  wire        armed_i,
   input  wire        compare_mode_bit_i,
   input  wire [7:0]  addr_i,
   input  wire        inbound_i,
   output reg         map_o
);

   reg  [7:0] mask;
   reg        hit;
   reg  [7:0] hi;
   reg  [7:0] lo;
   integer    k;

   ////////////////////////////////////////////////////////////////
   // compare against base/size or against bounds
   always @* begin
      mask = 8'h00;
      hit  = 1'b0;
      hi   = win_i[15:8];
      lo   = win_i[7:0];
      map_o = 1'b0;
      for (k = 0; k < 8; k = k + 1) begin
         if (k >= 8 - win_i[10:8])
            mask[k] = 1'b1;
      end
      if (!compare_mode_bit_i) begin
         hit = ((addr_i ^ win_i[7:0]) & mask) == 8'h00;
         if (win_i[`VXCFG_LA_EN_BIT] && armed_i) begin
            if (win_i[`VXCFG_LA_DIR_BIT] == inbound_i)
               map_o = hit;
            else
               map_o = !hit;
         end
      end else begin
         // bounds format, inward set is lo..hi-1
         if (hi == lo)
            hit = (hi <= `VXCFG_LA_MSB_RANGE);
         else if (hi > lo)
            hit = (addr_i >= lo) && (addr_i < hi);
         else
            hit = !((addr_i >= hi) && (addr_i < lo));
         if (armed_i && (win_i != 16'h0000))
            map_o = inbound_i ? hit : !hit;
      end
   end

endmodule

// file: verilog/vxcfg_regs.v
// vxcfg_regs.v - configuration register bank of the bus
// extender: identification, device type, status/control,
// module-select lines and logical address window.
// assumes: one clock, synchronous hard reset from the
// backplane system reset; register port driven by the local
// access decoder that serves both the backplane and the cable.
//
// Function
// - identification register fixed, ignores resets
// - device class reads extended, 01
// - address space reads A16 only, 11
// - low twelve bits hold maker code
// - device type fixed, memory field ones
// - model bit 11 low in slot 0
// - select status bit low when selected
// - extended type depends on daughter card
// - origin bit one for cable accesses
// - fixed hardware revision field readable
// - ready and passed read as one
// - soft reset bit written and readable
// - only hard reset clears soft reset
// - drive enable gates drivers, resets clear
// - drive bits set levels, reads live
// - window register cleared by hard reset
// - compare mode selects window format
// - base/size field layout, zero bits
// - disabled window still serves own address
// - direction bit picks mapped side
// - size sets compared base bits
// - window armed after lower byte write
`include "vxcfg_defines.vh"

module vxcfg_regs (
   input  wire        CLK_I,
   input  wire        SYS_RST_I,
   // register access port
   input  wire        REG_SEL_I,
   input  wire        REG_WR_I,
   input  wire [5:0]  REG_ADDR_I,
   input  wire [1:0]  REG_BE_I,
   input  wire [15:0] REG_WDATA_I,
   input  wire        REG_FROM_CABLE_I,
   output wire [15:0] REG_RDATA_O,
   output wire        REG_ACK_O,
   // pins from the backplane and the board
   input  wire        MODULE_SELECTED_N_I,
   input  wire        SLOT_ZERO_I,
   input  wire        CARD_PRESENT_I,
   input  wire [12:0] MODID_I,
   output wire [12:0] MODID_O,
   output wire [12:0] MODID_OE_O,
   output wire        SOFT_RESET_O,
   // window lookup from the cycle mapper
   input  wire        COMPARE_MODE_I,
   input  wire [7:0]  LA_OWN_I,
   input  wire        LA_QUERY_I,
   input  wire [7:0]  LA_ADDR_I,
   input  wire        LA_INBOUND_I,
   output wire        LA_MAP_O,
   output wire        LA_LOCAL_O,
   output wire        LA_DONE_O
);

   ////////////////////////////////////////////////////////////////
   // declarations

   // pin synchronisers, first stage read only by second
   reg  [12:0] modid_s1_r;
   reg  [12:0] modid_s2_r;
   reg         msel_s1_r;
   reg         msel_s2_r;
   reg         slot_s1_r;
   reg         slot_s2_r;
   reg         card_s1_r;
   reg         card_s2_r;

   // software state
   reg         srst_r;
   reg         drven_r;
   reg  [12:0] drive_r;
   reg  [15:0] lawin_r;
   reg         armed_r;

   // register port answer
   reg  [15:0] rdata_r;
   reg  [15:0] rdata_nxt;
   reg         ack_r;

   // pin drive
   reg  [12:0] modid_r;
   reg  [12:0] modid_oe_r;

   // window lookup answer
   reg         map_r;
   reg         local_r;
   reg         done_r;
   wire        map_nxt;

   // decoded access
   wire        wr_lo;
   wire        wr_hi;
   wire        hit_sc;
   wire        hit_ms;
   wire        hit_la;
   wire [5:0]  word_ofs;

   // assembled read words
   wire [15:0] ident_word;
   wire [15:0] devtype_word;
   wire [15:0] statctl_word;
   wire [15:0] modsel_word;

   ////////////////////////////////////////////////////////////////
   // pin synchronisers
   // straps too: they come from outside the clock domain
   always @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         modid_s1_r <= 13'h0000;
         modid_s2_r <= 13'h0000;
         msel_s1_r  <= 1'b1;
         msel_s2_r  <= 1'b1;
         slot_s1_r  <= 1'b0;
         slot_s2_r  <= 1'b0;
         card_s1_r  <= 1'b0;
         card_s2_r  <= 1'b0;
      end else begin
         modid_s1_r <= MODID_I;
         modid_s2_r <= modid_s1_r;
         msel_s1_r  <= MODULE_SELECTED_N_I;
         msel_s2_r  <= msel_s1_r;
         slot_s1_r  <= SLOT_ZERO_I;
         slot_s2_r  <= slot_s1_r;
         card_s1_r  <= CARD_PRESENT_I;
         card_s2_r  <= card_s1_r;
      end
   end

   ////////////////////////////////////////////////////////////////
   // address decode
   // even word offsets
   // bit 0 of the address is ignored: every register is a word
   assign word_ofs = {REG_ADDR_I[5:1], 1'b0};
   assign hit_sc   = word_ofs == `VXCFG_OFS_STATCTL;
   assign hit_ms   = word_ofs == `VXCFG_OFS_MODSEL;
   assign hit_la   = word_ofs == `VXCFG_OFS_LAWIN;

   // byte lanes of a write
   assign wr_lo = REG_SEL_I && REG_WR_I && REG_BE_I[0];
   assign wr_hi = REG_SEL_I && REG_WR_I && REG_BE_I[1];

   ////////////////////////////////////////////////////////////////
   // assembled read words
   // fixed identification word
   assign ident_word = {`VXCFG_DEVICE_CLASS_FIELD_EXT,
                        `VXCFG_ADDRSP_A16,
                        `VXCFG_MAKER_CODE};

   assign devtype_word = {`VXCFG_REQMEM_NONE,
                          !slot_s2_r,
                          `VXCFG_MODEL_LOW};

   // status word; origin bit is patched per access below
   // select status bit
   assign statctl_word = {1'b1,
                          msel_s2_r,
                          card_s2_r ? `VXCFG_EXTTYPE_CARD
                                    : `VXCFG_EXTTYPE_NONE,
                          1'b1,
                          1'b0,
                          `VXCFG_REVISION,
                          1'b1,
                          1'b1,
                          1'b1,
                          srst_r};

   assign modsel_word = {2'h0, drven_r, modid_s2_r};

   ////////////////////////////////////////////////////////////////
   // soft reset bit
   // soft reset control
   // only hard reset clears
   // the rest of the status word is fixed or follows the pins; hard reset loads the
   // select and card synchronisers, soft reset touches no other stored bit in it
   always @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         srst_r <= 1'b0;
      end else if (wr_lo && hit_sc) begin
         srst_r <= REG_WDATA_I[`VXCFG_SC_SRST_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////
   // module-select drive enable
   // both resets clear
   // held clear for as long as the soft reset bit stands,
   // so a write during soft reset cannot turn drivers on
   always @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         drven_r <= 1'b0;
      end else if (srst_r) begin
         drven_r <= 1'b0;
      end else if (wr_hi && hit_ms) begin
         drven_r <= REG_WDATA_I[`VXCFG_MS_DRVEN_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////
   // module-select drive bits
   // resets keep bits
   // no reset branch on purpose; value is unknown until the
   // first write, but the drivers are off until then
   always @(posedge CLK_I) begin
      if (wr_lo && hit_ms) begin
         drive_r[7:0] <= REG_WDATA_I[7:0];
      end
      if (wr_hi && hit_ms) begin
         drive_r[12:8] <= REG_WDATA_I[12:8];
      end
   end

   ////////////////////////////////////////////////////////////////
   // per-line pin drivers, two flip-flops each: level and enable
   // enable gates drivers
   genvar g;
   generate
      for (g = 0; g < `VXCFG_MS_LINES; g = g + 1) begin : g_line
         always @(posedge CLK_I) begin
            if (SYS_RST_I) begin
               modid_r[g]    <= 1'b0;
               modid_oe_r[g] <= 1'b0;
            end else begin
               modid_r[g]    <= drive_r[g] & drven_r;
               modid_oe_r[g] <= drven_r;
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////
   // logical address window register
   // hard reset clears
   // all bits stored: the bounds format needs the full upper byte
   always @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         lawin_r <= 16'h0000;
      end else begin
         if (wr_lo && hit_la) begin
            lawin_r[7:0] <= REG_WDATA_I[7:0];
         end
         if (wr_hi && hit_la) begin
            lawin_r[15:8] <= REG_WDATA_I[15:8];
         end
      end
   end

   ////////////////////////////////////////////////////////////////
   // window arming
   // lower byte arms
   // an upper-byte-only write disarms until the lower byte
   // follows; a full word write arms at once
   always @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         armed_r <= 1'b0;
      end else if (wr_lo && hit_la) begin
         armed_r <= 1'b1;
      end else if (wr_hi && hit_la) begin
         armed_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////
   // readback mux
   // unmapped and reserved offsets answer zero
   always @* begin
      rdata_nxt = 16'h0000;
      case (word_ofs)
         `VXCFG_OFS_IDENT: begin
            rdata_nxt = ident_word;
         end
         `VXCFG_OFS_DEVTYPE: begin
            rdata_nxt = devtype_word;
         end
         `VXCFG_OFS_STATCTL: begin
            rdata_nxt = statctl_word;
            rdata_nxt[`VXCFG_SC_ORIGIN_BIT] = REG_FROM_CABLE_I;
         end
         `VXCFG_OFS_MODSEL: begin
            rdata_nxt = modsel_word;
         end
         `VXCFG_OFS_LAWIN: begin
            // reserved bits read zero
            // only in base/size format; bounds format shows all bits
            if (COMPARE_MODE_I) begin
               rdata_nxt = lawin_r;
            end else begin
               rdata_nxt = lawin_r & `VXCFG_LA_WMASK;
            end
         end
         default: begin
            rdata_nxt = 16'h0000;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////
   // register port answer, one cycle after the select
   // read data stand until the next read access
   always @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         rdata_r <= 16'h0000;
         ack_r   <= 1'b0;
      end else begin
         ack_r <= REG_SEL_I;
         if (REG_SEL_I && !REG_WR_I) begin
            rdata_r <= rdata_nxt;
         end
      end
   end

   ////////////////////////////////////////////////////////////////
   // window comparator
   vxcfg_la_window u_win (
      .win_i     (lawin_r),
      .armed_i   (armed_r),
      .compare_mode_bit_i   (COMPARE_MODE_I),
      .addr_i    (LA_ADDR_I),
      .inbound_i (LA_INBOUND_I),
      .map_o     (map_nxt)
   );

   ////////////////////////////////////////////////////////////////
   // window lookup answer
   // own address always local
   // own address wins over the window so the configuration
   // space stays reachable whatever software wrote
   always @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         map_r   <= 1'b0;
         local_r <= 1'b0;
         done_r  <= 1'b0;
      end else begin
         done_r <= LA_QUERY_I;
         if (LA_QUERY_I) begin
            local_r <= LA_ADDR_I == LA_OWN_I;
            map_r   <= map_nxt && (LA_ADDR_I != LA_OWN_I);
         end
      end
   end

   ////////////////////////////////////////////////////////////////
   // outputs, all straight from flip-flops
   assign REG_RDATA_O  = rdata_r;
   assign REG_ACK_O    = ack_r;
   assign MODID_O      = modid_r;
   assign MODID_OE_O   = modid_oe_r;
   assign SOFT_RESET_O = srst_r;
   assign LA_MAP_O     = map_r;
   assign LA_LOCAL_O   = local_r;
   assign LA_DONE_O    = done_r;

endmodule

// file: test/vxcfg_regs_asserts.sv
// vxcfg_regs_asserts.sv - port checks for the register bank.
// assumes: bound to vxcfg_regs; one clock, synchronous reset.
module vxcfg_regs_chk (
   input logic        CLK_I,
   input logic        SYS_RST_I,
   input logic        REG_SEL_I,
   input logic        REG_WR_I,
   input logic [5:0]  REG_ADDR_I,
   input logic        REG_FROM_CABLE_I,
   input logic [15:0] REG_RDATA_O,
   input logic        REG_ACK_O,
   input logic [12:0] MODID_O,
   input logic [12:0] MODID_OE_O,
   input logic        SOFT_RESET_O,
   input logic        COMPARE_MODE_I,
   input logic        LA_QUERY_I,
   input logic [7:0]  LA_ADDR_I,
   input logic [7:0]  LA_OWN_I,
   input logic        LA_MAP_O,
   input logic        LA_LOCAL_O,
   input logic        LA_DONE_O
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (SYS_RST_I);
   // read request decode, shared by the field checks
   wire       rd_take = REG_SEL_I && !REG_WR_I;
   wire [4:0] rd_word = REG_ADDR_I[5:1];

   ////////////////////////////////////////////////////////////////
   ack_after_sel_a: assert property (REG_SEL_I |=> REG_ACK_O)
      else $error("no ack after access");
   ack_has_cause_a: assert property (REG_ACK_O |-> $past(REG_SEL_I))
      else $error("ack without access");
   ident_fixed_a: assert property (rd_take && rd_word == 5'h00 |=> REG_RDATA_O == 16'h75a5)
      else $error("identification value wrong");
   devtype_fixed_a: assert property (rd_take && rd_word == 5'h01
      |=> REG_RDATA_O[15:12] == 4'hf && REG_RDATA_O[10:0] == 11'h0a5)
      else $error("device type value wrong");
   status_ones_a: assert property (rd_take && rd_word == 5'h02
      |=> REG_RDATA_O[15] && REG_RDATA_O[9] && REG_RDATA_O[3:1] == 3'h7)
      else $error("status fixed ones wrong");
   origin_bit_a: assert property (rd_take && rd_word == 5'h02
      |=> REG_RDATA_O[8] == $past(REG_FROM_CABLE_I))
      else $error("origin bit wrong");
   unmapped_zero_a: assert property (rd_take && rd_word == 5'h03 |=> REG_RDATA_O == 16'h0000)
      else $error("unmapped read not zero");
   window_zero_a: assert property (rd_take && rd_word == 5'h05 && !COMPARE_MODE_I
      |=> !REG_RDATA_O[15] && !REG_RDATA_O[12])
      else $error("window reserved bits set");
   drive_gated_a: assert property (MODID_OE_O == {13{MODID_OE_O[0]}}
      && (MODID_OE_O[0] || MODID_O == 13'h0000))
      else $error("select line drive not gated");
   srst_blocks_a: assert property (SOFT_RESET_O [*3] |-> MODID_OE_O == 13'h0000)
      else $error("drivers on in soft reset");
   lookup_done_a: assert property (LA_QUERY_I |=> LA_DONE_O)
      else $error("lookup not answered");
   own_local_a: assert property (LA_QUERY_I && LA_ADDR_I == LA_OWN_I |=> LA_LOCAL_O && !LA_MAP_O)
      else $error("own address mapped");
   // main scenarios reached
   cover property (LA_QUERY_I && LA_ADDR_I == LA_OWN_I);
   cover property (SOFT_RESET_O [*3]);
   cover property (REG_SEL_I && REG_WR_I && rd_word == 5'h05);
endmodule

bind vxcfg_regs vxcfg_regs_chk u_chk (
   .CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I), .REG_SEL_I(REG_SEL_I), .REG_WR_I(REG_WR_I),
   .REG_ADDR_I(REG_ADDR_I), .REG_FROM_CABLE_I(REG_FROM_CABLE_I), .REG_RDATA_O(REG_RDATA_O),
   .REG_ACK_O(REG_ACK_O), .MODID_O(MODID_O), .MODID_OE_O(MODID_OE_O), .SOFT_RESET_O(SOFT_RESET_O),
   .COMPARE_MODE_I(COMPARE_MODE_I), .LA_QUERY_I(LA_QUERY_I), .LA_ADDR_I(LA_ADDR_I),
   .LA_OWN_I(LA_OWN_I), .LA_MAP_O(LA_MAP_O),
   .LA_LOCAL_O(LA_LOCAL_O), .LA_DONE_O(LA_DONE_O));

// file: test/vxcfg_bp_model.sv
// vxcfg_bp_model.sv - backplane module-select lines seen by the bank.
// assumes: lines carry a pull level when no driver is on.
module vxcfg_bp_model #(
   parameter logic [12:0] PULL = 13'h1fff
) (
   input  logic [12:0] drv_i,
   input  logic [12:0] oe_i,
   output logic [12:0] line_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // released lines go to the pull level, never keep the old value
   assign line_o = (oe_i & drv_i) | (~oe_i & PULL);
endmodule

// file: test/tb.sv
// tb.sv - self-checking bench for the configuration register bank.
// assumes: inputs move on the falling edge; checker bound by its file.
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 0, rst = 1, sel = 0, wr = 0, org = 0, seln = 1, slot = 1, card = 0;
   logic        compare_mode_bit = 0, q = 0, inb = 0, ack, srst, map, loc, done;
   logic [5:0]  addr = 0;
   logic [1:0]  be = 0;
   logic [15:0] wd = 0, rdata;
   logic [7:0]  own = 8'h10, qa = 0;
   logic [12:0] mid, mo, moe;
   int          err_count = 0, cmp_count = 0, cyc = 0;

   always #10 clk = ~clk;

   vxcfg_regs dut (.CLK_I(clk), .SYS_RST_I(rst), .REG_SEL_I(sel), .REG_WR_I(wr), .REG_ADDR_I(addr),
      .REG_BE_I(be), .REG_WDATA_I(wd), .REG_FROM_CABLE_I(org), .REG_RDATA_O(rdata), .REG_ACK_O(ack),
      .MODULE_SELECTED_N_I(seln), .SLOT_ZERO_I(slot), .CARD_PRESENT_I(card), .MODID_I(mid),
      .MODID_O(mo), .MODID_OE_O(moe), .SOFT_RESET_O(srst), .COMPARE_MODE_I(compare_mode_bit), .LA_OWN_I(own),
      .LA_QUERY_I(q), .LA_ADDR_I(qa), .LA_INBOUND_I(inb), .LA_MAP_O(map), .LA_LOCAL_O(loc),
      .LA_DONE_O(done));
   vxcfg_bp_model bp (.drv_i(mo), .oe_i(moe), .line_o(mid));

   ////////////////////////////////////////////////////////////////
   task automatic finish_test;
      $display("compares %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // one access: strobe held over the taking edge, ack looked at next cycle
   task automatic acc(input logic w, input logic [5:0] a, input logic [1:0] b, input logic [15:0] d);
      @(negedge clk);
      sel = 1; wr = w; addr = a; be = b; wd = d;
      @(negedge clk);
      sel = 0;
      chk({15'h0, ack}, 16'h0001);
   endtask
   task automatic rd(input logic [5:0] a, input logic [15:0] exp);
      acc(0, a, 2'b00, 16'h0000);
      chk(rdata, exp);
   endtask
   task automatic lk(input logic [7:0] a, input logic in, input logic [1:0] exp);
      @(negedge clk);
      q = 1; qa = a; inb = in;
      @(negedge clk);
      q = 0;
      chk({13'h0, done, loc, map}, {13'h0, 1'b1, exp});
   endtask
   // synced straps and lines need two edges after release
   task automatic hreset(input int n);
      @(negedge clk);
      rst = 1;
      repeat (n) @(negedge clk);
      rst = 0;
      repeat (3) @(negedge clk);
   endtask
   function automatic logic [15:0] st(input logic n, c, o, s);
      return {1'b1, n, c ? 4'h9 : 4'h8, 1'b1, o, 4'h7, 3'h7, s};
   endfunction

   // hang guard, the whole run needs well under a thousand cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         finish_test;
      end
   end

   ////////////////////////////////////////////////////////////////
   initial begin
      hreset(16);
      rd(6'h00, 16'h75a5);
      acc(1, 6'h00, 2'b11, 16'h0000);
      rd(6'h00, 16'h75a5);
      rd(6'h02, 16'hf0a5);
      slot = 0;
      repeat (3) @(negedge clk);
      rd(6'h02, 16'hf8a5);
      $display("identification test done");
      seln = 0; card = 1; org = 1;
      repeat (3) @(negedge clk);
      rd(6'h04, st(0, 1, 1, 0));
      seln = 1; card = 0; org = 0;
      repeat (3) @(negedge clk);
      rd(6'h04, st(1, 0, 0, 0));
      acc(1, 6'h04, 2'b11, 16'hffff);
      rd(6'h04, st(1, 0, 0, 1));
      chk({15'h0, srst}, 16'h0001);
      hreset(2);
      rd(6'h04, st(1, 0, 0, 0));
      $display("status test done");
      // slot 0 strap restored; drive enable does not depend on it
      slot = 1;
      acc(1, 6'h08, 2'b11, 16'h3555);
      repeat (3) @(negedge clk);
      chk({3'h0, moe}, 16'h1fff);
      chk({3'h0, mo}, 16'h1555);
      rd(6'h08, 16'h3555);
      acc(1, 6'h04, 2'b11, 16'h0001);
      repeat (3) @(negedge clk);
      chk({3'h0, moe}, 16'h0000);
      acc(1, 6'h04, 2'b11, 16'h0000);
      acc(1, 6'h08, 2'b10, 16'h3500);
      repeat (3) @(negedge clk);
      chk({3'h0, mo}, 16'h1555);
      hreset(2);
      chk({3'h0, moe}, 16'h0000);
      rd(6'h08, 16'h1fff);
      // low drive byte must have survived the hard reset
      acc(1, 6'h08, 2'b10, 16'h2000);
      repeat (3) @(negedge clk);
      chk({3'h0, mo}, 16'h0055);
      $display("select line test done");
      rd(6'h0a, 16'h0000);
      acc(1, 6'h0a, 2'b11, 16'hffff);
      rd(6'h0a, 16'h67ff);
      acc(1, 6'h0a, 2'b11, 16'h64a0);
      lk(8'ha5, 1, 2'b01);
      lk(8'hb0, 1, 2'b00);
      lk(8'hb0, 0, 2'b01);
      lk(8'ha5, 0, 2'b00);
      lk(8'h10, 1, 2'b10);
      acc(1, 6'h0a, 2'b11, 16'h67a4);
      lk(8'ha5, 1, 2'b01);
      lk(8'ha6, 1, 2'b00);
      acc(1, 6'h0a, 2'b11, 16'h6012);
      lk(8'hff, 1, 2'b01);
      acc(1, 6'h0a, 2'b10, 16'h6400);
      lk(8'h15, 1, 2'b00);
      acc(1, 6'h0a, 2'b01, 16'h0012);
      lk(8'h15, 1, 2'b01);
      acc(1, 6'h0a, 2'b11, 16'h24a0);
      lk(8'ha5, 1, 2'b00);
      lk(8'h10, 0, 2'b10);
      compare_mode_bit = 1;
      acc(1, 6'h0a, 2'b11, 16'h4020);
      lk(8'h30, 1, 2'b01);
      lk(8'h50, 1, 2'b00);
      lk(8'h50, 0, 2'b01);
      // bounds format keeps the full upper byte
      acc(1, 6'h0a, 2'b11, 16'h9080);
      rd(6'h0a, 16'h9080);
      lk(8'h85, 1, 2'b01);
      lk(8'h95, 1, 2'b00);
      $display("window test done");
      acc(1, 6'h06, 2'b11, 16'hffff);
      rd(6'h06, 16'h0000);
      rd(6'h0c, 16'h0000);
      rd(6'h3e, 16'h0000);
      $display("unmapped test done");
      finish_test;
   end
endmodule
